// file: hdl/aswf_consts.svh
// Constants for the sample word formatter
`ifndef ASWF_CONSTS_SVH
`define ASWF_CONSTS_SVH
`define ASWF_SAMPLE_W 12
`define ASWF_WORD_W 16
`define ASWF_SIGN_BIT 11
`define ASWF_OVR_BIT 15
`define ASWF_BYTE_LSB 4
`define ASWF_INDEX_W 32
`define ASWF_FIFO_DEPTH 8
`define ASWF_ZERO_WORD 16'h0000
`endif

// file: hdl/aswf_formatter.sv
// Sample word formatter with output FIFO and memory readout window
`timescale 1ns/10ps
`default_nettype none
`include "aswf_consts.svh"

module aswf_fifo #(
  parameter int WIDTH = `ASWF_WORD_W,
  parameter int DEPTH = `ASWF_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Handshakes; full and empty come from the count
  always_comb begin
    push = i_in_valid && (count != (AW+1)'(DEPTH));
    pop = (count != '0) && i_out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage array has no reset; contents are guarded by count
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
endmodule : aswf_fifo

module aswf_formatter #(
  parameter int DEPTH = `ASWF_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_overrange_enable,
  input wire logic i_dual_channel_byte_pack_enable,
  input wire logic i_channel_share,
  input wire logic i_sample_valid,
  output logic o_sample_ready,
  input wire logic [`ASWF_SAMPLE_W-1:0] i_converter_channel_sample_first,
  input wire logic [`ASWF_SAMPLE_W-1:0] i_converter_channel_sample_second,
  input wire logic i_overrange_first,
  input wire logic i_overrange_second,
  input wire logic [`ASWF_INDEX_W-1:0] i_readout_start,
  input wire logic [`ASWF_INDEX_W-1:0] i_readout_length,
  input wire logic i_readout_begin,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [`ASWF_WORD_W-1:0] o_word,
  output logic [`ASWF_INDEX_W-1:0] o_word_index,
  output logic o_readout_active
);
  // Mirror of FIFO fill so the ready flop can look one cycle ahead
  localparam int FW = $clog2(DEPTH) + 1;
  logic [FW-1:0] fill, next_fill;
  aswf_pkg::aswf_format_e format;
  aswf_pkg::aswf_phase_e phase, next_phase;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, in_valid, take;
  logic [`ASWF_WORD_W-1:0] fifo_out_data, packed_word;
  logic [`ASWF_SAMPLE_W-1:0] cur_sample;
  logic cur_ovr;
  logic [`ASWF_INDEX_W-1:0] index, next_index, remain, next_remain;
  logic [`ASWF_INDEX_W-1:0] next_word_index;
  logic active, next_active, next_word_valid;
  logic [`ASWF_WORD_W-1:0] next_word;

  // Packing wins over overrange; channel sharing is ignored while packing
  always_comb begin
    if (i_dual_channel_byte_pack_enable) begin
      format = aswf_pkg::ASWF_FMT_BYTE_PACK;
    end else if (i_overrange_enable) begin
      format = aswf_pkg::ASWF_FMT_OVERRANGE;
    end else begin
      format = aswf_pkg::ASWF_FMT_SIGN_EXT;
    end
  end

  // Pick the sample for this slot; shared streams alternate
  always_comb begin
    cur_sample = i_converter_channel_sample_first;
    cur_ovr = i_overrange_first;
    if (i_channel_share && format != aswf_pkg::ASWF_FMT_BYTE_PACK &&
        phase == aswf_pkg::ASWF_ST_SECOND) begin
      cur_sample = i_converter_channel_sample_second;
      cur_ovr = i_overrange_second;
    end
  end

  // Word layout per format
  always_comb begin
    case (format)
      aswf_pkg::ASWF_FMT_BYTE_PACK: begin
        packed_word = {i_converter_channel_sample_second[`ASWF_SAMPLE_W-1:`ASWF_BYTE_LSB],
                       i_converter_channel_sample_first[`ASWF_SAMPLE_W-1:`ASWF_BYTE_LSB]};
      end
      aswf_pkg::ASWF_FMT_OVERRANGE: begin
        // Flag replaces the top sign copy only
        packed_word = {cur_ovr, {3{cur_sample[`ASWF_SIGN_BIT]}}, cur_sample};
      end
      default: begin
        // Plain sign extension keeps -2048..+2047 intact
        packed_word = {{4{cur_sample[`ASWF_SIGN_BIT]}}, cur_sample};
      end
    endcase
  end

  // A slot is taken only when ready was offered; no word can be lost to a full FIFO
  always_comb begin
    take = i_sample_valid && o_sample_ready && fifo_in_ready;
    in_valid = take;
    next_fill = fill + FW'(take) - FW'(fifo_pop);
    next_phase = phase;
    if (take && i_channel_share && format != aswf_pkg::ASWF_FMT_BYTE_PACK) begin
      next_phase = (phase == aswf_pkg::ASWF_ST_FIRST) ? aswf_pkg::ASWF_ST_SECOND : aswf_pkg::ASWF_ST_FIRST;
    end else if (!i_channel_share || format == aswf_pkg::ASWF_FMT_BYTE_PACK) begin
      next_phase = aswf_pkg::ASWF_ST_FIRST;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= aswf_pkg::ASWF_ST_FIRST;
      fill <= '0;
      o_sample_ready <= 1'b0;
    end else begin
      phase <= next_phase;
      fill <= next_fill;
      o_sample_ready <= (next_fill != FW'(DEPTH));
    end
  end

  aswf_fifo #(
    .WIDTH(`ASWF_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_in_valid(in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(packed_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );

  // Readout window counted in output words, not samples or bytes
  always_comb begin
    next_index = index;
    next_remain = remain;
    next_active = active;
    next_word_valid = o_word_valid;
    next_word = o_word;
    next_word_index = o_word_index;
    fifo_pop = 1'b0;
    if (o_word_valid && i_word_ready) begin
      next_word_valid = 1'b0;
    end
    if (i_readout_begin) begin
      next_index = i_readout_start;
      next_remain = i_readout_length;
      next_active = (i_readout_length != '0);
    end else if (active && fifo_out_valid && (!o_word_valid || i_word_ready)) begin
      fifo_pop = 1'b1;
      next_word_valid = 1'b1;
      next_word = fifo_out_data;
      next_word_index = index;
      next_index = index + 32'h00000001;
      next_remain = remain - 32'h00000001;
      next_active = (remain != 32'h00000001);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      index <= '0;
      remain <= '0;
      active <= 1'b0;
      o_word_valid <= 1'b0;
      o_word <= `ASWF_ZERO_WORD;
      o_word_index <= '0;
      o_readout_active <= 1'b0;
    end else begin
      index <= next_index;
      remain <= next_remain;
      active <= next_active;
      o_word_valid <= next_word_valid;
      o_word <= next_word;
      o_word_index <= next_word_index;
      o_readout_active <= next_active;
    end
  end
endmodule : aswf_formatter
`default_nettype wire

// file: hdl/aswf_pkg.sv
// Types for the sample word formatter
package aswf_pkg;
  typedef enum logic [1:0] {
    ASWF_FMT_SIGN_EXT = 2'b00,
    ASWF_FMT_OVERRANGE = 2'b01,
    ASWF_FMT_BYTE_PACK = 2'b11
  } aswf_format_e;
  typedef enum logic [1:0] {
    ASWF_ST_FIRST = 2'b00,
    ASWF_ST_SECOND = 2'b01
  } aswf_phase_e;
endpackage : aswf_pkg

// file: testbench/aswf_formatter_sva.sv
// Handshake and word layout checks for the formatter
`timescale 1ns/10ps
`default_nettype none
`include "aswf_consts.svh"
module aswf_formatter_sva (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_overrange_enable,
  input wire logic i_dual_channel_byte_pack_enable,
  input wire logic [`ASWF_INDEX_W-1:0] i_readout_length,
  input wire logic i_readout_begin,
  input wire logic o_word_valid,
  input wire logic i_word_ready,
  input wire logic [`ASWF_WORD_W-1:0] o_word,
  input wire logic [`ASWF_INDEX_W-1:0] o_word_index,
  input wire logic o_readout_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_take; o_word_valid && i_word_ready; endsequence
  logic std;
  assign std = o_word_valid && !i_dual_channel_byte_pack_enable;
  property p_hold; o_word_valid && !i_word_ready |=> $stable(o_word) && $stable(o_word_index); endproperty
  a_hold: assert property (p_hold) else $error("stall");
  property p_idx; s_take |=> !o_word_valid || o_word_index == $past(o_word_index) + 1; endproperty
  a_idx: assert property (p_idx) else $error("index");
  property p_end; s_take ##0 !o_readout_active |=> !o_word_valid; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_sign; std && !i_overrange_enable |-> o_word[15:12] == {4{o_word[11]}}; endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_ovr; std && i_overrange_enable |-> o_word[14:12] == {3{o_word[11]}}; endproperty
  a_ovr: assert property (p_ovr) else $error("ovr");
  property p_len0; i_readout_begin && i_readout_length == 0 && !o_readout_active |=> !o_readout_active [*3]; endproperty
  a_len0: assert property (p_len0) else $error("len0");
  property p_open; i_readout_begin && i_readout_length > 1 |-> ##[1:2] o_readout_active; endproperty
  a_open: assert property (p_open) else $error("open");
  property p_rst; $rose(i_nrst) |-> !o_word_valid && !o_readout_active; endproperty
  a_rst: assert property (p_rst) else $error("reset");
endmodule : aswf_formatter_sva
bind aswf_formatter aswf_formatter_sva i_sva (.*);
`default_nettype wire

// file: testbench/aswf_sink.sv
// Memory reader model that drains formatted words
`timescale 1ns/10ps
`default_nettype none
module aswf_sink (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_slow,
  output logic o_ready
);
  logic [1:0] cnt;
  // Slow reader takes one word in four, so the buffer backs up
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  assign o_ready = !i_slow || cnt == 2'h0;
endmodule : aswf_sink
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the sample word formatter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, nrst, ovr, pk, sh, sv, oa, ob, beg, slow, srdy, wv, rdy, act;
  logic [11:0] sa, sb;
  logic [15:0] w, q[$];
  logic [31:0] st, len, wi, idx, r = 32'h00001acd;
  int fail_count = 0, total_checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  aswf_formatter i_aswf_formatter (.i_clock(clk), .i_nrst(nrst), .i_overrange_enable(ovr),
    .i_dual_channel_byte_pack_enable(pk), .i_channel_share(sh), .i_sample_valid(sv), .o_sample_ready(srdy),
    .i_converter_channel_sample_first(sa), .i_converter_channel_sample_second(sb), .i_overrange_first(oa),
    .i_overrange_second(ob), .i_readout_start(st), .i_readout_length(len), .i_readout_begin(beg),
    .o_word_valid(wv), .i_word_ready(rdy), .o_word(w), .o_word_index(wi), .o_readout_active(act));
  aswf_sink i_aswf_sink (.i_clock(clk), .i_nrst(nrst), .i_slow(slow), .o_ready(rdy));
  function automatic logic [31:0] rnd();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return r;
  endfunction : rnd
  function automatic logic [15:0] fmt(logic [11:0] a, logic [11:0] b, logic o);
    return pk ? {b[11:4], a[11:4]} : ovr ? {o, {3{a[11]}}, a} : {{4{a[11]}}, a};
  endfunction : fmt
  task chk(string n, logic [31:0] g, logic [31:0] e);
    total_checks++;
    fail_count += (g !== e);
    if (g !== e) $display("[ERR] %s expected %h seen %h", n, e, g);
  endtask : chk
  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task open();
    beg = 1'h1;
    @(posedge clk) #1;
    beg = 1'h0;
  endtask : open
  // Reader side: each taken word in order; hang guard last
  always @(posedge clk) begin
    if (wv === 1'h1 && rdy === 1'h1) begin
      chk("word", {16'h0, w}, {16'h0, q.pop_front()});
      chk("index", wi, idx++);
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // One window per call; pre fills the buffer before the window opens
  task run(logic [1:0] m, logic s, logic pre, int n);
    int k;
    {pk, ovr} = m;
    sh = s;
    k = (s && !m[1]) ? 2 : 1;
    st = (rnd() & 32'hff) * k;
    len = n * k;
    idx = st;
    if (!pre) open();
    for (int j = 0; j < n; j++) begin
      void'(rnd());
      sa = (pre && j < 2) ? (j ? 12'h7ff : 12'h800) : r[11:0];
      {ob, oa, sb} = r[25:12];
      q.push_back(fmt(sa, sb, oa));
      if (k == 2) q.push_back(fmt(sb, sb, ob));
      sv = 1'h1;
      for (int u = 0; u < k; u++) begin
        while (srdy !== 1'h1) @(posedge clk) #1;
        @(posedge clk) #1;
      end
      sv = 1'h0;
    end
    if (pre) open();
    for (int t = 0; t < 300 && (act === 1'h1 || q.size() > 0); t++) @(posedge clk) #1;
    chk("left", 32'(q.size()), 32'h0);
    $display("test done format %b share %b", m, s);
  endtask : run
  // Reset, fill, every format with random lengths, then an empty window
  initial begin
    {nrst, ovr, pk, sh, sv, oa, ob, beg, slow} = 9'h0;
    {sa, sb, st, len} = 88'h0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'h1;
    @(posedge clk) #1;
    run(2'h0, 1'h0, 1'h1, 8);
    for (int i = 0; i < 9; i++) begin
      slow = i[0];
      run(i % 3 == 2 ? {1'h1, i[3]} : 2'(i % 3), i / 3 == 1 && i % 3 != 2, 1'h0, 1 + int'(rnd() % 32'h6));
    end
    len = 32'h0;
    open();
    repeat (3) @(posedge clk) #1;
    chk("empty", {31'h0, act}, 32'h0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
